// ==== verilog/bacp_params.svh ====
// timing, width and register constants for the converter pacing pair
`ifndef BACP_PARAMS_SVH
`define BACP_PARAMS_SVH
`define BACP_CORE_HZ 50000000
`define BACP_OSC_HZ 4915200
`define BACP_EXT_THRESH_HZ 200000
`define BACP_DET_WIN_US 100
`define BACP_DET_WIN_CYC (`BACP_CORE_HZ / 1000000 * `BACP_DET_WIN_US)
`define BACP_DET_EDGES (`BACP_EXT_THRESH_HZ / 1000 * `BACP_DET_WIN_US / 1000)
`define BACP_SLOW_PERIOD 491520
`define BACP_FAST_PERIOD 61440
`define BACP_MOD_DIV 64
`define BACP_SETTLE_FAST_MS 51
`define BACP_SETTLE_SLOW_MS 401
`define BACP_SETTLE_FAST_CLK (`BACP_SETTLE_FAST_MS * `BACP_OSC_HZ / 1000)
`define BACP_SETTLE_SLOW_CLK (`BACP_SETTLE_SLOW_MS * `BACP_OSC_HZ / 1000)
`define BACP_UPDATE_US 39
`define BACP_UPDATE_CLK ((`BACP_UPDATE_US * `BACP_OSC_HZ + 999999) / 1000000)
`define BACP_SLOW_SHIFT 28
`define BACP_FAST_SHIFT 16
`define BACP_CIC_W 60
`define BACP_WORD_W 24
`define BACP_WORD_MAX 24'h7FFFFF
`define BACP_WORD_MIN 24'h800000
`define BACP_SCLK_HALF_CYC 8
`define BACP_DISCARD_N 3'h4
`define BACP_OFF_CTRL 8'h00
`define BACP_OFF_STATUS 8'h04
`define BACP_OFF_DATA 8'h08
`define BACP_OFF_INT_STAT 8'h0C
`define BACP_OFF_INT_MASK 8'h10
`define BACP_CTRL_RUN 0
`define BACP_CTRL_FAST 1
`define BACP_CTRL_CH_LO 2
`define BACP_CTRL_CH_HI 3
`define BACP_CTRL_TEMP 4
`define BACP_CTRL_DISCARD 5
`define BACP_CTRL_RST 5'h00
`define BACP_INT_WORD 0
`define BACP_INT_OVER 1
`endif

// ==== verilog/bacp_pkg.sv ====
// types shared by both ends of the converter link
package bacp_pkg;
    typedef enum {LINE_IDLE, LINE_UPDATE, LINE_READY, LINE_SHIFT} bacp_line_t;
    typedef enum {H_IDLE, H_WAIT, H_HIGH, H_LOW, H_FHIGH, H_FLOW} bacp_host_t;
endpackage : bacp_pkg

// ==== verilog/bacp_link_if.sv ====
// pin bundle between converter and host
`timescale 1ns/1ps
interface bacp_link_if;
    logic clock_or_crystal_in;
    logic crystal_drive_out;
    logic rate_fast;
    logic channel_sel_lo;
    logic channel_sel_hi;
    logic temp_sel;
    logic sclk;
    logic ready_and_serial_out;
    modport device (
        input clock_or_crystal_in, rate_fast, channel_sel_lo, channel_sel_hi, temp_sel, sclk,
        output crystal_drive_out, ready_and_serial_out
    );
    modport host (
        output rate_fast, channel_sel_lo, channel_sel_hi, temp_sel, sclk,
        input ready_and_serial_out
    );
endinterface : bacp_link_if

// ==== verilog/bacp_device.sv ====
// converter end: clock sensing, conversion pacing, sinc4 filter, ready/serial line
//
// What this block does
// - fast clock pin: use it, oscillator off
// - slow or grounded pin: internal oscillator
// - system grounds pin for internal oscillator
// - slow rate: word every 491520 periods
// - fast rate: word every 61440 periods
// - sinc4 decimator at clock over 64
// - low-pass cutoff follows rate setting
// - all timing counted in clock periods
// - rate scaling needs an external clock
// - channel change holds ready high until settled
// - hold lasts 51 or 401 ms
// - host discards four readings after steps
// - temperature toggle uses host discard
// - result is 24-bit two's complement
// - results clip at full-scale codes
// - one step per code, zero is zero
// - ready low, then MSB first per edge
`timescale 1ns/1ps
`include "bacp_params.svh"
module bacp_device import bacp_pkg::*; #(
    parameter int DET_WIN = `BACP_DET_WIN_CYC,
    parameter int SLOW_PERIOD = `BACP_SLOW_PERIOD,
    parameter int FAST_PERIOD = `BACP_FAST_PERIOD,
    parameter int SETTLE_FAST = `BACP_SETTLE_FAST_CLK,
    parameter int SETTLE_SLOW = `BACP_SETTLE_SLOW_CLK
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // pins
    bacp_link_if.device link,
    // modulator bitstream, core clock domain
    input wire logic mod_bit,
    // status
    output logic clk_sense,
    output logic [23:0] result
);
    localparam int CW = `BACP_CIC_W;
    localparam int NS = 5;

    logic [NS-1:0] pin_s1;
    logic [NS-1:0] pin_s2;
    logic [NS-1:0] pin_s3;
    logic [12:0] win_cnt_reg;
    logic [7:0] edge_cnt_reg;
    logic ext_reg;
    logic [25:0] acc_reg;
    logic fclk_tick;
    logic [5:0] mod_cnt_reg;
    logic mod_tick;
    logic [12:0] dec_cnt_reg;
    logic conv_end;
    logic [20:0] settle_cnt_reg;
    logic hold_reg;
    logic settle_done;
    logic chan_change;
    logic new_word;
    logic [7:0] upd_cnt_reg;
    logic [23:0] filt_reg;
    logic [23:0] shift_reg;
    logic [4:0] bit_cnt_reg;
    logic line_reg;
    logic sclk_rise;
    bacp_line_t line_st;
    logic signed [CW-1:0] integ [4];
    logic signed [CW-1:0] dly [4];
    logic signed [CW-1:0] comb [5];
    logic signed [CW-1:0] scaled;

    // clip a scaled filter value to the 24-bit code range
    function automatic logic [23:0] bacp_clip(input logic signed [CW-1:0] v);
        if (v > $signed(CW'(`BACP_WORD_MAX)))
            return `BACP_WORD_MAX;
        else if (v < -$signed(CW'(`BACP_WORD_MAX)) - 1)
            return `BACP_WORD_MIN;
        else
            return v[23:0];
    endfunction : bacp_clip

    // two-flop synchronisers for every pin input except temp_sel, third stage for edges
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= (gi == 0) ? link.clock_or_crystal_in :
                                  (gi == 1) ? link.rate_fast :
                                  (gi == 2) ? link.channel_sel_lo :
                                  (gi == 3) ? link.channel_sel_hi : link.sclk;
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                end
            end
        end
    endgenerate
    assign sclk_rise = pin_s2[4] & ~pin_s3[4];
    assign chan_change = (pin_s2[3:2] != pin_s3[3:2]);
    // count pin edges per window to sense an external clock
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            win_cnt_reg <= 13'h0000;
            edge_cnt_reg <= 8'h00;
            ext_reg <= 1'b0;
        end else if (win_cnt_reg == 13'(DET_WIN - 1)) begin
            win_cnt_reg <= 13'h0000;
            edge_cnt_reg <= 8'h00;
            ext_reg <= (edge_cnt_reg >= 8'(`BACP_DET_EDGES));
        end else begin
            win_cnt_reg <= win_cnt_reg + 13'h0001;
            if (pin_s2[0] & ~pin_s3[0] && edge_cnt_reg != 8'hFF)
                edge_cnt_reg <= edge_cnt_reg + 8'h01;
        end
    end

    // internal oscillator as fractional divider, off while external runs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            acc_reg <= 26'h0000000;
        else if (ext_reg)
            acc_reg <= 26'h0000000;
        else if (acc_reg + 26'(`BACP_OSC_HZ) >= 26'(`BACP_CORE_HZ))
            acc_reg <= acc_reg + 26'(`BACP_OSC_HZ) - 26'(`BACP_CORE_HZ);
        else
            acc_reg <= acc_reg + 26'(`BACP_OSC_HZ);
    end

    // one tick per selected clock period
    assign fclk_tick = ext_reg ? (pin_s2[0] & ~pin_s3[0]) :
                       (acc_reg + 26'(`BACP_OSC_HZ) >= 26'(`BACP_CORE_HZ));
    assign clk_sense = ~ext_reg;
    // crystal amplifier output follows the inverted pin, held low while external runs
    assign link.crystal_drive_out = ~pin_s2[0] & ~ext_reg;

    // modulator rate divider and decimation counter
    assign mod_tick = fclk_tick && mod_cnt_reg == 6'(`BACP_MOD_DIV - 1);
    assign conv_end = mod_tick && dec_cnt_reg == (pin_s2[1] ?
                      13'(FAST_PERIOD / `BACP_MOD_DIV - 1) : 13'(SLOW_PERIOD / `BACP_MOD_DIV - 1));
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mod_cnt_reg <= 6'h00;
            dec_cnt_reg <= 13'h0000;
        end else if (chan_change || settle_done) begin
            mod_cnt_reg <= 6'h00;
            dec_cnt_reg <= 13'h0000;
        end else if (fclk_tick) begin
            mod_cnt_reg <= mod_cnt_reg + 6'h01;
            if (conv_end)
                dec_cnt_reg <= 13'h0000;
            else if (mod_tick)
                dec_cnt_reg <= dec_cnt_reg + 13'h0001;
        end
    end
    // four integrators at modulator rate, four combs at word rate
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cic
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    integ[gi] <= '0;
                    dly[gi] <= '0;
                end else begin
                    if (mod_tick)
                        integ[gi] <= integ[gi] + ((gi == 0) ?
                                     (mod_bit ? CW'(1) : -CW'(1)) : integ[(gi == 0) ? 0 : gi - 1]);
                    if (conv_end)
                        dly[gi] <= comb[gi];
                end
            end
            assign comb[gi+1] = comb[gi] - dly[gi];
        end
    endgenerate
    assign comb[0] = integ[3];
    // gain normalised per rate, so cutoff tracks the rate
    assign scaled = pin_s2[1] ? (comb[4] >>> `BACP_FAST_SHIFT) : (comb[4] >>> `BACP_SLOW_SHIFT);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            filt_reg <= 24'h000000;
        else if (conv_end)
            filt_reg <= bacp_clip(scaled);
    end
    // settling hold after a channel select change, its last tick shows the word
    assign settle_done = hold_reg && fclk_tick && settle_cnt_reg ==
                         (pin_s2[1] ? 21'(SETTLE_FAST - 2) : 21'(SETTLE_SLOW - 2));
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_reg <= 1'b0;
            settle_cnt_reg <= 21'h000000;
        end else if (chan_change) begin
            hold_reg <= 1'b1;
            settle_cnt_reg <= 21'h000000;
        end else if (settle_done) begin
            hold_reg <= 1'b0;
        end else if (hold_reg && fclk_tick) begin
            settle_cnt_reg <= settle_cnt_reg + 21'h000001;
        end
    end
    assign new_word = settle_done || (conv_end && !hold_reg);
    // data ready and serial output line
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_st <= LINE_IDLE;
            line_reg <= 1'b1;
            upd_cnt_reg <= 8'h00;
            shift_reg <= 24'h000000;
            bit_cnt_reg <= 5'h00;
            result <= 24'h000000;
        end else if (chan_change || (hold_reg && !settle_done)) begin
            line_st <= LINE_IDLE;
            line_reg <= 1'b1;
        end else if (new_word) begin
            line_st <= LINE_UPDATE;
            line_reg <= 1'b1;
            upd_cnt_reg <= settle_done ? 8'(`BACP_UPDATE_CLK - 1) : 8'h00; // settled word skips the gap
        end else begin
            case (line_st)
                LINE_IDLE: begin
                    line_reg <= 1'b1;
                end
                LINE_UPDATE: begin
                    if (fclk_tick) begin
                        if (upd_cnt_reg == 8'(`BACP_UPDATE_CLK - 1)) begin
                            line_st <= LINE_READY;
                            line_reg <= 1'b0;
                            shift_reg <= filt_reg;
                            result <= filt_reg;
                            bit_cnt_reg <= 5'h00;
                        end else begin
                            upd_cnt_reg <= upd_cnt_reg + 8'h01;
                        end
                    end
                end
                LINE_READY, LINE_SHIFT: begin
                    if (sclk_rise) begin
                        line_st <= LINE_SHIFT;
                        if (bit_cnt_reg == 5'(`BACP_WORD_W)) begin
                            line_st <= LINE_IDLE;
                            line_reg <= 1'b1;
                        end else begin
                            line_reg <= shift_reg[23];
                            shift_reg <= {shift_reg[22:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end
                end
                default: begin
                    line_st <= LINE_IDLE;
                    line_reg <= 1'b1;
                end
            endcase
        end
    end
    assign link.ready_and_serial_out = line_reg;
endmodule : bacp_device

// ==== verilog/bacp_host.sv ====
// host end: APB registers, polling sequencer, reading discard, interrupt
`timescale 1ns/1ps
`include "bacp_params.svh"
module bacp_host import bacp_pkg::*; #(
    parameter int SCLK_HALF = `BACP_SCLK_HALF_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // pins
    bacp_link_if.host link
);
    logic [4:0] ctrl_reg;
    logic [23:0] data_reg;
    logic [23:0] sh_reg;
    logic [1:0] int_stat_reg;
    logic [1:0] int_mask_reg;
    logic [1:0] int_set;
    logic [2:0] discard_reg;
    logic [4:0] bit_cnt_reg;
    logic [7:0] half_cnt_reg;
    logic sclk_reg;
    logic rdy_s1;
    logic rdy_s2;
    logic wr;
    logic half_done;
    logic word_done;
    bacp_host_t st;

    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign half_done = (half_cnt_reg == 8'(SCLK_HALF - 1));
    assign word_done = (st == H_FLOW) && half_done;

    // decode a mapped register address
    function automatic logic bacp_mapped(input logic [7:0] a);
        return a == `BACP_OFF_CTRL || a == `BACP_OFF_STATUS || a == `BACP_OFF_DATA ||
               a == `BACP_OFF_INT_STAT || a == `BACP_OFF_INT_MASK;
    endfunction : bacp_mapped

    // read mux and error answer
    always_comb begin
        prdata = 32'h00000000;
        pslverr = psel & penable & ~bacp_mapped(paddr);
        case (paddr)
            `BACP_OFF_CTRL: prdata = {27'h0000000, ctrl_reg};
            `BACP_OFF_STATUS: prdata = {21'h000000, discard_reg, 6'h00, ~rdy_s2, st != H_WAIT && st != H_IDLE};
            `BACP_OFF_DATA: prdata = {8'h00, data_reg};
            `BACP_OFF_INT_STAT: prdata = {30'h00000000, int_stat_reg};
            `BACP_OFF_INT_MASK: prdata = {30'h00000000, int_mask_reg};
            default: prdata = 32'h00000000;
        endcase
    end

    // control register drives the pins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            ctrl_reg <= `BACP_CTRL_RST;
        else if (wr && paddr == `BACP_OFF_CTRL)
            ctrl_reg <= pwdata[4:0];
    end
    assign link.rate_fast = ctrl_reg[`BACP_CTRL_FAST];
    assign link.channel_sel_lo = ctrl_reg[`BACP_CTRL_CH_LO];
    assign link.channel_sel_hi = ctrl_reg[`BACP_CTRL_CH_HI];
    assign link.temp_sel = ctrl_reg[`BACP_CTRL_TEMP];
    assign link.sclk = sclk_reg;

    // readings left to throw away after an input step
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            discard_reg <= 3'h0;
        else if (wr && paddr == `BACP_OFF_CTRL &&
                 (pwdata[`BACP_CTRL_DISCARD] || pwdata[`BACP_CTRL_TEMP] != ctrl_reg[`BACP_CTRL_TEMP]))
            discard_reg <= `BACP_DISCARD_N;
        else if (word_done && discard_reg != 3'h0)
            discard_reg <= discard_reg - 3'h1;
    end

    // interrupt status, set wins over write-one-clear
    assign int_set[`BACP_INT_WORD] = word_done && discard_reg == 3'h0;
    assign int_set[`BACP_INT_OVER] = int_set[`BACP_INT_WORD] && int_stat_reg[`BACP_INT_WORD];
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_stat_reg <= 2'h0;
            int_mask_reg <= 2'h0;
        end else begin
            if (wr && paddr == `BACP_OFF_INT_STAT)
                int_stat_reg <= (int_stat_reg & ~pwdata[1:0]) | int_set;
            else
                int_stat_reg <= int_stat_reg | int_set;
            if (wr && paddr == `BACP_OFF_INT_MASK)
                int_mask_reg <= pwdata[1:0];
        end
    end
    assign irq = |(int_stat_reg & int_mask_reg);

    // line synchroniser
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_s1 <= 1'b1;
            rdy_s2 <= 1'b1;
        end else begin
            rdy_s1 <= link.ready_and_serial_out;
            rdy_s2 <= rdy_s1;
        end
    end

    // polling and shift sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= H_IDLE;
            sclk_reg <= 1'b0;
            half_cnt_reg <= 8'h00;
            bit_cnt_reg <= 5'h00;
            sh_reg <= 24'h000000;
            data_reg <= 24'h000000;
        end else begin
            half_cnt_reg <= half_done ? 8'h00 : half_cnt_reg + 8'h01;
            case (st)
                H_IDLE: begin
                    if (ctrl_reg[`BACP_CTRL_RUN])
                        st <= H_WAIT;
                end
                H_WAIT: begin
                    half_cnt_reg <= 8'h00;
                    bit_cnt_reg <= 5'h00;
                    if (!ctrl_reg[`BACP_CTRL_RUN]) begin
                        st <= H_IDLE;
                    end else if (!rdy_s2) begin
                        st <= H_HIGH;
                        sclk_reg <= 1'b1;
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        st <= H_LOW;
                        sclk_reg <= 1'b0;
                    end
                end
                H_LOW: begin
                    if (half_done) begin
                        sh_reg <= {sh_reg[22:0], rdy_s2};
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        sclk_reg <= 1'b1;
                        st <= (bit_cnt_reg == 5'(`BACP_WORD_W - 1)) ? H_FHIGH : H_HIGH;
                    end
                end
                H_FHIGH: begin
                    if (half_done) begin
                        st <= H_FLOW;
                        sclk_reg <= 1'b0;
                    end
                end
                H_FLOW: begin
                    if (half_done) begin
                        st <= H_WAIT;
                        if (discard_reg == 3'h0)
                            data_reg <= sh_reg;
                    end
                end
                default: begin
                    st <= H_IDLE;
                    sclk_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule : bacp_host

// ==== bench/bacp_link_props.sv ====
// link pin checks for the converter and host pair
`timescale 1ns/1ps
module bacp_link_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // link pins
    input wire logic channel_sel_lo,
    input wire logic channel_sel_hi,
    input wire logic sclk,
    input wire logic ready_and_serial_out
);
    logic sclk_d_reg;
    logic [4:0] pulse_reg;
    logic [5:0] idle_reg;
    logic [8:0] hi_run_reg;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // serial clock rises counted per read, cleared after a quiet spell
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d_reg <= 1'b0;
            pulse_reg <= 5'h00;
            idle_reg <= 6'h00;
        end else begin
            sclk_d_reg <= sclk;
            idle_reg <= sclk ? 6'h00 : idle_reg + {5'h00, idle_reg != 6'h3F};
            if (idle_reg == 6'h20) pulse_reg <= 5'h00;
            else if (sclk && !sclk_d_reg) pulse_reg <= pulse_reg + 5'h01;
        end
    end
    // length of the current high run on the line, saturating
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) hi_run_reg <= 9'h000;
        else if (!ready_and_serial_out) hi_run_reg <= 9'h000;
        else if (hi_run_reg != 9'h1FF) hi_run_reg <= hi_run_reg + 9'h001;
    end
    sequence moved_s;
        $changed(channel_sel_lo) || $changed(channel_sel_hi);
    endsequence
    sequence held_s;
        ready_and_serial_out [*8];
    endsequence
    chan_hold_a: assert property (moved_s |-> ##4 held_s)
        else $error("line not held high after channel change");
    sclk_high_a: assert property (sclk && !sclk_d_reg |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high half wrong");
    sclk_low_a: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("serial clock low half wrong");
    end_force_a: assert property (sclk && !sclk_d_reg && pulse_reg == 5'h18 |-> ##5 held_s)
        else $error("line not high after extra pulse");
    pulse_limit_a: assert property (sclk && !sclk_d_reg |-> pulse_reg < 5'h19)
        else $error("more than 25 pulses in a read");
    read_start_a: assert property (sclk && !sclk_d_reg && pulse_reg == 5'h00 |-> $past(ready_and_serial_out, 2) == 1'b0)
        else $error("read began without ready low");
    update_gap_a: assert property ($fell(ready_and_serial_out) && pulse_reg == 5'h00 |-> hi_run_reg == 9'h1FF)
        else $error("word signalled without update gap");
    bit_edge_a: assert property (pulse_reg inside {[5'h01:5'h18]} && $changed(ready_and_serial_out) |-> sclk)
        else $error("data bit moved outside clock high");
endmodule : bacp_link_props

// ==== bench/tb_top.sv ====
// self-checking bench for the converter and host pair
`timescale 1ns/1ps
module tb_top;
    localparam int FP = 640;
    localparam int SP = 1280;
    localparam int SF = 1500;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [23:0] result;
    logic pready, pslverr, irq, clk_sense, er, ch;
    logic mod_bit = 1'b0;
    logic ext_clk = 1'b0;
    logic ext_en = 1'b0;
    logic line_d = 1'b1;
    int fails = 0;
    int n_tests = 0;
    int seed = 47422;
    int cyc = 0;
    int idle = 0;
    int wt = 0;
    int t0, t1, cw;
    bacp_link_if link_i ();
    // pin grounded unless the external clock runs
    assign link_i.clock_or_crystal_in = ext_en & ext_clk;
    bacp_device #(.SLOW_PERIOD(SP), .FAST_PERIOD(FP), .SETTLE_FAST(SF), .SETTLE_SLOW(3000)) bacp_device_i (
        .core_clk(core_clk), .rst_b(rst_b), .link(link_i), .mod_bit(mod_bit), .clk_sense(clk_sense), .result(result));
    bacp_host bacp_host_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link_i));
    bacp_link_props bacp_link_props_i (.core_clk(core_clk), .rst_b(rst_b), .channel_sel_lo(link_i.channel_sel_lo),
        .channel_sel_hi(link_i.channel_sel_hi), .sclk(link_i.sclk), .ready_and_serial_out(link_i.ready_and_serial_out));
    // core clock and free-running external clock
    always #10 core_clk = ~core_clk;
    // rate scaled only by the external clock
    always #80 ext_clk = ~ext_clk;
    // random modulator bits, cycle count, word-start detection
    always @(posedge core_clk) begin
        mod_bit <= 1'($random(seed));
        cyc <= cyc + 1;
        idle <= link_i.sclk ? 0 : idle + 1;
        line_d <= link_i.ready_and_serial_out;
        if (line_d && !link_i.ready_and_serial_out && idle > 20) wt <= cyc;
    end
    // core cycles for a count of external clock ticks
    function automatic int ext_cyc(input int n);
        return n * 8;
    endfunction : ext_cyc
    task automatic stop_test();
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer, read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wait_word(output int t);
        int w;
        w = wt;
        for (int n = 0; n < 40000 && wt == w; n++) @(posedge core_clk);
        t = wt;
        chk("word_seen", 1, 32'(wt != w));
    endtask : wait_word
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        // internal oscillator, fast words, word interrupt unmasked
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h00, 32'h3);
        wait_word(t0);
        wait_word(t1);
        chk("osc_in_use", 32'h1, {31'h0, clk_sense});
        chk("osc_period", 32'h1, 32'((t1 - t0) inside {[6508:6513]}));
        repeat (500) @(posedge core_clk);
        apb(1'b0, 8'h08, 32'h0);
        chk("word_data", {8'h00, result}, rd);
        chk("irq_set", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h10, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b0, 8'h0C, 32'h0);
        chk("stat_clear", 32'h0, rd);
        // external clock takes over
        ext_en <= 1'b1;
        wait_word(t0);
        wait_word(t0);
        wait_word(t1);
        chk("ext_in_use", 32'h0, {31'h0, clk_sense});
        chk("ext_fast_period", ext_cyc(FP), t1 - t0);
        // slow rate
        apb(1'b1, 8'h00, 32'h1);
        wait_word(t0);
        wait_word(t0);
        wait_word(t1);
        chk("ext_slow_period", ext_cyc(SP), t1 - t0);
        // back to fast, then a channel change holds the line
        repeat (500) @(posedge core_clk);
        apb(1'b1, 8'h00, 32'h3);
        repeat (20) @(posedge core_clk);
        ch = 1'($random(seed));
        cw = cyc;
        apb(1'b1, 8'h00, {27'h0, 1'b0, ch, 3'h7});
        wait_word(t1);
        chk("settle_hold", 32'h1, 32'((t1 - cw) inside {[ext_cyc(SF) - 8:ext_cyc(SF) + 16]}));
        // armed discard suppresses the next word
        repeat (500) @(posedge core_clk);
        apb(1'b1, 8'h00, {26'h0, 2'h2, ch, 3'h7});
        apb(1'b0, 8'h04, 32'h0);
        chk("discard_count", 32'h4, {29'h0, rd[10:8]});
        apb(1'b1, 8'h0C, 32'h3);
        wait_word(t1);
        repeat (500) @(posedge core_clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("discard_no_flag", 32'h0, rd);
        // temperature select toggle re-arms the discard count
        apb(1'b1, 8'h00, {28'h1, ch, 3'h7});
        apb(1'b0, 8'h04, 32'h0);
        chk("temp_rearm", 32'h4, {29'h0, rd[10:8]});
        stop_test();
    end
    // watchdog
    initial begin
        #(98000 * 20);
        fails++;
        stop_test();
    end
endmodule : tb_top
